// ---- verilog/crc_cfg.svh ----
// constants for the clock and reset control block: register map,
// field positions, reset values and stabilisation counts.
// assumes byte-wide registers on a plain address/strobe port.
`ifndef CRC_CFG_SVH
`define CRC_CFG_SVH

// register addresses
`define CRC_ADDR_CTRL 24'hff_fc40
`define CRC_ADDR_FAST 24'hff_fc42
`define CRC_ADDR_SLOW 24'hff_fc44
`define CRC_ADDR_AUX 24'hff_fc46

// control register bit positions
`define CRC_SCLK_BIT 0
`define CRC_FAST_SRC_SEL_BIT 1
`define CRC_PWD_BIT 2
`define CRC_AUX1_ENABLE_BIT 3
`define CRC_AUX2_ENABLE_BIT 4
`define CRC_POR_BIT 5

// fast prescaler fields
`define CRC_DIV_LSB 0
`define CRC_DIV_MSB 3
`define CRC_MODE_LSB 4
`define CRC_MODE_MSB 6

// reset values
`define CRC_FAST_RST 8'h4f
`define CRC_SLOW_RST 8'hb6
`define CRC_AUX_RST 8'hff

// pll modes and their multiplication factors
`define CRC_MODE_X3 3'h3
`define CRC_MODE_X4 3'h4
`define CRC_MODE_X5 3'h5

// oscillator stabilisation counter preset
`define CRC_STAB_PRESET 14'h3fff

`endif

// ---- verilog/crc_pkg.sv ----
// types shared by the clock and reset control block.
// assumes the constants header is included where numbers are needed.
package crc_pkg;

	// oscillator start-up phase, one-hot
	typedef enum logic [2:0] {
		CRC_HOLD = 3'h1,
		CRC_COUNT = 3'h2,
		CRC_RUN = 3'h4
	} crc_phase_t;

	// whole state of the control block
	typedef struct packed {
		crc_phase_t phase;
		logic [13:0] stab_cnt;
		logic main_good;
		logic chip_reset_n;
		logic slow_src_sel;
		logic fast_src_sel;
		logic pll_powerdown;
		logic aux1_enable;
		logic aux2_enable;
		logic por_flag;
		logic [3:0] sys_clock_divisor;
		logic [2:0] pll_mode;
		logic [2:0] pll_mult;
		logic [7:0] slow_div;
		logic [7:0] aux_div;
		logic pll_stable;
		logic [7:0] rdata;
	} crc_state_t;

	// state of one clock-enable divider
	typedef struct packed {
		logic [8:0] cnt;
		logic tick;
	} crc_div_state_t;

endpackage : crc_pkg

// ---- verilog/crc_divider.sv ----
// clock-enable divider: one tick every div+1 enabled cycles.
// assumes sys_clk, synchronous active-low reset and a global clock enable.
`timescale 1ns/1ps
module crc_divider (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// control
	input wire logic run,
	input wire logic [8:0] div,
	// output
	output logic tick
);

	crc_pkg::crc_div_state_t q;
	crc_pkg::crc_div_state_t n;

	// count up to the divisor, then emit one tick and wrap
	always_comb begin
		n = q;
		if (!rst_n) begin
			n.cnt = 9'h000;
			n.tick = 1'h0;
		end else if (clk_en) begin
			if (!run) begin
				n.cnt = 9'h000;
				n.tick = 1'h0;
			end else if (q.cnt >= div) begin
				n.cnt = 9'h000; // >= copes with a divisor lowered midway
				n.tick = 1'h1;
			end else begin
				n.cnt = q.cnt + 9'h001;
				n.tick = 1'h0;
			end
		end
	end

	// state register
	always_ff @(posedge sys_clk) begin
		q <= n;
	end

	assign tick = q.tick;

endmodule : crc_divider

// ---- verilog/crc_ctrl.sv ----
// clock selection and power-on reset control block.
// assumes synchronous pin inputs and a plain register port on sys_clk.
//
// Overview of operation
// RULE1 - 14-bit count from 3FFF; reset releases at zero unless pin low
// RULE2 - external supervisor holds reset low until both supplies are valid
// RULE3 - supervisor asserts reset on supply drop until main clock stops
// RULE4 - bit 0 picks prescaled main clock (0) or 32.768 kHz oscillator (1)
// RULE5 - bit 1 picks pll (0) or main clock (1); resets to 1
// RULE6 - switching to the pll is ignored while pll is powered down
// RULE7 - switching to the pll is ignored until pll output is stable
// RULE8 - bit 2 powers the pll down when 1; resets to 1
// RULE9 - setting pll power-down is ignored while pll is the source
// RULE10 - aux clock 1 runs only when bit 3 set and main clock stable
// RULE11 - aux clock 2 runs only when bit 4 set and main clock stable
// RULE12 - bit 5 power-on flag set by hardware, cleared by writing 0
// RULE13 - system clock divided by divisor field plus one
// RULE14 - pll mode field bits 6..4 resets to 100b, 48 MHz
// RULE15 - fast prescaler resets to 4Fh except in programming mode
// RULE16 - software leaves fast prescaler alone while running from the pll
// RULE17 - pll multiplies main clock by three, four or five per mode
// RULE18 - reserved register bits read zero and ignore writes
`timescale 1ns/1ps
`include "crc_cfg.svh"
module crc_ctrl #(
	parameter logic [13:0] STAB_PRESET = `CRC_STAB_PRESET
) (
	// clock, reset, freeze
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// pins and status from the analog side
	input wire logic ext_reset_n,
	input wire logic osc_stable,
	input wire logic pll_locked,
	input wire logic slow_osc_good,
	input wire logic prog_mode,
	// register port
	input wire logic [23:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// reset and clock control outputs
	output logic chip_reset_n,
	output logic main_clock_good,
	output logic slow_src_sel,
	output logic fast_src_sel,
	output logic pll_stop,
	output logic [2:0] pll_mode,
	output logic [2:0] pll_mult,
	// clock-enable ticks
	output logic sys_tick,
	output logic aux1_tick,
	output logic aux2_tick,
	output logic slow_tick
);

	crc_pkg::crc_state_t q;
	crc_pkg::crc_state_t n;
	logic wr_ctrl;
	logic wr_fast;
	logic wr_slow;
	logic wr_aux;
	// reset image of the fast prescaler, split into its fields on reset
	localparam logic [7:0] FAST_RST = `CRC_FAST_RST;

	// write decode
	assign wr_ctrl = reg_wr && (reg_addr == `CRC_ADDR_CTRL);
	assign wr_fast = reg_wr && (reg_addr == `CRC_ADDR_FAST);
	assign wr_slow = reg_wr && (reg_addr == `CRC_ADDR_SLOW);
	assign wr_aux = reg_wr && (reg_addr == `CRC_ADDR_AUX);

	// next state of the whole block
	always_comb begin
		n = q;
		if (!rst_n) begin
			n.phase = crc_pkg::CRC_HOLD;
			n.stab_cnt = STAB_PRESET; // RULE1
			n.main_good = 1'h0;
			n.chip_reset_n = 1'h0;
			n.slow_src_sel = 1'h0;
			n.fast_src_sel = 1'h1; // RULE5
			n.pll_powerdown = 1'h1; // RULE8
			n.aux1_enable = 1'h0; // RULE10
			n.aux2_enable = 1'h0; // RULE11
			n.por_flag = 1'h1; // RULE12
			n.slow_div = `CRC_SLOW_RST;
			n.aux_div = `CRC_AUX_RST;
			n.pll_stable = 1'h0;
			n.rdata = 8'h00;
			// programming mode keeps the fast prescaler
			if (!prog_mode) begin
				n.sys_clock_divisor =
					FAST_RST[`CRC_DIV_MSB:`CRC_DIV_LSB]; // RULE15
				n.pll_mode =
					FAST_RST[`CRC_MODE_MSB:`CRC_MODE_LSB]; // RULE14
			end
		end else if (clk_en) begin
			n.pll_stable = pll_locked & ~q.pll_powerdown;
			// oscillator start-up sequence
			unique case (q.phase)
				crc_pkg::CRC_HOLD: begin
					n.main_good = 1'h0;
					n.stab_cnt = STAB_PRESET;
					if (osc_stable) begin
						n.phase = crc_pkg::CRC_COUNT; // RULE1
					end
				end
				crc_pkg::CRC_COUNT: begin
					if (!osc_stable) begin
						n.phase = crc_pkg::CRC_HOLD;
						n.stab_cnt = STAB_PRESET;
					end else if (q.stab_cnt == 14'h0000) begin
						n.phase = crc_pkg::CRC_RUN; // RULE1
						n.main_good = 1'h1;
					end else begin
						n.stab_cnt = q.stab_cnt - 14'h0001; // RULE1
					end
				end
				crc_pkg::CRC_RUN: begin
					if (!osc_stable) begin
						n.phase = crc_pkg::CRC_HOLD;
						n.main_good = 1'h0;
						n.stab_cnt = STAB_PRESET;
					end
				end
				default: begin
					n.phase = crc_pkg::CRC_HOLD;
					n.main_good = 1'h0;
					n.stab_cnt = STAB_PRESET;
				end
			endcase
			// internal reset follows counter and the pin
			n.chip_reset_n = q.main_good & ext_reset_n; // RULE1
			// control register writes
			if (wr_ctrl) begin
				// oscillator may only be chosen once it runs
				if (!reg_wdata[`CRC_SCLK_BIT] || slow_osc_good) begin
					n.slow_src_sel = reg_wdata[`CRC_SCLK_BIT]; // RULE4
				end
				if (reg_wdata[`CRC_FAST_SRC_SEL_BIT]) begin
					n.fast_src_sel = 1'h1; // RULE5
				end else if (!q.pll_powerdown && q.pll_stable) begin
					n.fast_src_sel = 1'h0; // RULE6 RULE7
				end
				if (!reg_wdata[`CRC_PWD_BIT]) begin
					n.pll_powerdown = 1'h0; // RULE8
				end else if (q.fast_src_sel) begin
					n.pll_powerdown = 1'h1; // RULE9
				end
				n.aux1_enable = reg_wdata[`CRC_AUX1_ENABLE_BIT]; // RULE10
				n.aux2_enable = reg_wdata[`CRC_AUX2_ENABLE_BIT]; // RULE11
				if (!reg_wdata[`CRC_POR_BIT]) begin
					n.por_flag = 1'h0; // RULE12
				end
			end
			// fast prescaler, bit 7 dropped
			if (wr_fast) begin
				n.sys_clock_divisor =
					reg_wdata[`CRC_DIV_MSB:`CRC_DIV_LSB]; // RULE13
				n.pll_mode =
					reg_wdata[`CRC_MODE_MSB:`CRC_MODE_LSB]; // RULE18
			end
			if (wr_slow) begin
				n.slow_div = reg_wdata;
			end
			if (wr_aux) begin
				n.aux_div = reg_wdata;
			end
			// read data for exactly one cycle
			n.rdata = 8'h00;
			if (reg_rd) begin
				unique case (reg_addr)
					`CRC_ADDR_CTRL: begin
						n.rdata = {2'h0, q.por_flag, q.aux2_enable,
							q.aux1_enable, q.pll_powerdown,
							q.fast_src_sel, q.slow_src_sel}; // RULE18
					end
					`CRC_ADDR_FAST: begin
						n.rdata = {1'h0, q.pll_mode,
							q.sys_clock_divisor}; // RULE18
					end
					`CRC_ADDR_SLOW: begin
						n.rdata = q.slow_div;
					end
					`CRC_ADDR_AUX: begin
						n.rdata = q.aux_div;
					end
					default: begin
						n.rdata = 8'h00; // unmapped reads zero
					end
				endcase
			end
		end
		// multiplication factor, zero for reserved modes
		unique case (n.pll_mode)
			`CRC_MODE_X3: n.pll_mult = 3'h3; // RULE17
			`CRC_MODE_X4: n.pll_mult = 3'h4; // RULE17
			`CRC_MODE_X5: n.pll_mult = 3'h5; // RULE17
			default: n.pll_mult = 3'h0;
		endcase
	end

	// state register
	always_ff @(posedge sys_clk) begin
		q <= n;
	end

	// system clock divider on the selected fast source
	crc_divider u_sys_div (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.run(q.main_good),
		.div({5'h00, q.sys_clock_divisor}), // RULE13
		.tick(sys_tick)
	);

	// auxiliary clock 1, gated by enable and a stable main clock
	crc_divider u_aux1_div (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.run(q.aux1_enable & q.main_good), // RULE10
		.div({5'h00, q.aux_div[7:4]}),
		.tick(aux1_tick)
	);

	// auxiliary clock 2, gated the same way
	crc_divider u_aux2_div (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.run(q.aux2_enable & q.main_good), // RULE11
		.div({5'h00, q.aux_div[3:0]}),
		.tick(aux2_tick)
	);

	// slow prescaler, off once the oscillator drives the slow clock
	crc_divider u_slow_div (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.run(q.main_good & ~q.slow_src_sel), // RULE4
		.div({q.slow_div, 1'h1}), // period 2*(div+1)
		.tick(slow_tick)
	);

	// outputs straight from the state register
	assign reg_rdata = q.rdata;
	assign chip_reset_n = q.chip_reset_n;
	assign main_clock_good = q.main_good;
	assign slow_src_sel = q.slow_src_sel;
	assign fast_src_sel = q.fast_src_sel;
	assign pll_stop = q.pll_powerdown;
	assign pll_mode = q.pll_mode;
	assign pll_mult = q.pll_mult;

	// checks on the block's own behaviour
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	sequence stab_expired;
		clk_en && q.phase == crc_pkg::CRC_COUNT && q.stab_cnt == 14'h0000
			&& osc_stable;
	endsequence

	sequence clear_fast_req;
		clk_en && wr_ctrl && !reg_wdata[`CRC_FAST_SRC_SEL_BIT] && q.fast_src_sel;
	endsequence

	stab_release_a: assert property ( // RULE1
		stab_expired |=> main_clock_good ##1
			(!$past(clk_en) || chip_reset_n == $past(ext_reset_n))
	) else $error("main clock good not raised at count end");

	reset_gate_a: assert property ( // RULE1
		$rose(chip_reset_n) |-> $past(main_clock_good) && $past(ext_reset_n)
	) else $error("internal reset released too early");

	pll_off_a: assert property ( // RULE6
		clear_fast_req ##0 q.pll_powerdown |=> fast_src_sel
	) else $error("pll selected while powered down");

	pll_unstable_a: assert property ( // RULE7
		clear_fast_req ##0 !q.pll_stable |=> fast_src_sel
	) else $error("pll selected before stable");

	pll_switch_a: assert property ( // RULE5
		clear_fast_req ##0 (q.pll_stable && !q.pll_powerdown)
			|=> !fast_src_sel
	) else $error("valid pll select not taken");

	pwd_guard_a: assert property ( // RULE9
		clk_en && wr_ctrl && reg_wdata[`CRC_PWD_BIT] && !fast_src_sel
			&& !pll_stop |=> !pll_stop
	) else $error("pll powered down while selected");

	por_keep_a: assert property ( // RULE12
		clk_en && wr_ctrl && reg_wdata[`CRC_POR_BIT] |=> $stable(q.por_flag)
	) else $error("power-on flag changed by writing one");

	por_clear_a: assert property ( // RULE12
		clk_en && wr_ctrl && !reg_wdata[`CRC_POR_BIT] |=> !q.por_flag
	) else $error("power-on flag not cleared");

	aux1_gate_a: assert property ( // RULE10
		aux1_tick |-> $past(q.aux1_enable) && $past(main_clock_good)
	) else $error("aux clock 1 ran while disabled");

	aux2_gate_a: assert property ( // RULE11
		aux2_tick |-> $past(q.aux2_enable) && $past(main_clock_good)
	) else $error("aux clock 2 ran while disabled");

	sys_div_a: assert property ( // RULE13
		(sys_tick && clk_en && main_clock_good
			&& q.sys_clock_divisor == 4'h1)
			##1 (clk_en && main_clock_good
			&& q.sys_clock_divisor == 4'h1)
			|-> !sys_tick ##1 sys_tick
	) else $error("system divider period wrong");

	reset_vals_a: assert property ( // RULE14
		$rose(rst_n) && !$past(prog_mode) |-> pll_mode == 3'h4
			&& pll_mult == 3'h4 && fast_src_sel && pll_stop
			&& q.sys_clock_divisor == 4'hf
	) else $error("wrong values after reset");

	reserved_zero_a: assert property ( // RULE18
		clk_en && reg_rd && (reg_addr == `CRC_ADDR_CTRL)
			|=> reg_rdata[7:6] == 2'h0
	) else $error("reserved control bits read non-zero");

	slow_src_a: assert property ( // RULE4
		slow_tick |-> !$past(slow_src_sel)
	) else $error("prescaler ran with oscillator selected");

	pin_reset_a: assert property ( // RULE1
		clk_en && !ext_reset_n |=> !chip_reset_n
	) else $error("internal reset ignored the pin");

	prog_keep_a: assert property ( // RULE15
		$rose(rst_n) && $past(prog_mode) |-> $stable(q.sys_clock_divisor)
			&& $stable(q.pll_mode)
	) else $error("fast prescaler lost in programming mode");

endmodule : crc_ctrl

// ---- test/crc_supervisor.sv ----
// external reset supervisor model driving the active-low reset pin.
// assumes rail-good flags and a main-clock-running flag from the bench.
`timescale 1ns/1ps
module crc_supervisor #(
	parameter int HOLD = 8
) (
	// clock
	input wire logic sys_clk,
	// supply and main clock status
	input wire logic io_ok,
	input wire logic core_ok,
	input wire logic main_run,
	// reset pin
	output logic ext_reset_n
);
	int cnt = 0;
	logic down = 1'b0;
	// low while a rail is short; after a drop, low until clock has stopped
	always @(posedge sys_clk) begin
		if (!(io_ok && core_ok)) begin
			cnt <= 0;
		end else if (!down && cnt < HOLD) begin
			cnt <= cnt + 1;
		end
		// a drop after release is a power-down, not a power-up
		if (!main_run) begin
			down <= 1'b0;
		end else if (!(io_ok && core_ok) && cnt == HOLD) begin
			down <= 1'b1;
		end
	end
	// pin released only after both rails held good for a while
	assign ext_reset_n = io_ok && core_ok && !down && cnt == HOLD;
endmodule : crc_supervisor

// ---- test/clock_reset_control_tb_top.sv ----
// self-checking bench for the clock and reset control block.
// assumes the supervisor model and a shortened stabilisation count.
`timescale 1ns/1ps
`include "crc_cfg.svh"
module clock_reset_control_tb_top;
	localparam logic [13:0] STAB = 14'h0010;
	logic sys_clk = 1'b0, rst_n = 1'b0, osc_stable = 1'b0;
	logic pll_locked = 1'b0, slow_osc_good = 1'b1, prog_mode = 1'b0;
	logic io_ok = 1'b0, core_ok = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [23:0] reg_addr = 24'h00_0000;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata, v, vf;
	logic [2:0] pll_mode, pll_mult;
	logic ext_reset_n, chip_reset_n, main_clock_good, slow_src_sel;
	logic fast_src_sel, pll_stop, sys_tick, aux1_tick, aux2_tick, slow_tick;
	logic [31:0] seed = 32'h44b4_c48e;
	logic [15:0] p;
	int err_total = 0, samples_checked = 0, cyc = 0, n;
	logic [7:0] cw [6] = '{8'h00, 8'h00, 8'h00, 8'h24, 8'h02, 8'hde};
	logic [7:0] ce [6] = '{8'h02, 8'h02, 8'h00, 8'h00, 8'h02, 8'h1e};

	// 100 MHz clock
	always #5 sys_clk = ~sys_clk;

	crc_supervisor #(.HOLD(8)) SUP (.sys_clk(sys_clk), .io_ok(io_ok),
		.core_ok(core_ok), .main_run(osc_stable), .ext_reset_n(ext_reset_n));

	crc_ctrl #(.STAB_PRESET(STAB)) DUT (.sys_clk(sys_clk), .rst_n(rst_n),
		.clk_en(1'b1), .ext_reset_n(ext_reset_n), .osc_stable(osc_stable),
		.pll_locked(pll_locked), .slow_osc_good(slow_osc_good),
		.prog_mode(prog_mode), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.chip_reset_n(chip_reset_n), .main_clock_good(main_clock_good),
		.slow_src_sel(slow_src_sel), .fast_src_sel(fast_src_sel),
		.pll_stop(pll_stop), .pll_mode(pll_mode), .pll_mult(pll_mult),
		.sys_tick(sys_tick), .aux1_tick(aux1_tick), .aux2_tick(aux2_tick),
		.slow_tick(slow_tick));

	// xorshift source of random values
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xs

	// expected multiplication factor per mode
	function automatic logic [2:0] mult_of(input logic [2:0] m);
		case (m)
			3'h3: return 3'h3;
			3'h4: return 3'h4;
			3'h5: return 3'h5;
			default: return 3'h0;
		endcase
	endfunction : mult_of

	// pick one tick output
	function automatic logic tk(input int s);
		case (s)
			0: return sys_tick;
			1: return aux1_tick;
			2: return aux2_tick;
			default: return slow_tick;
		endcase
	endfunction : tk

	task automatic chk(input string what, input logic [15:0] e,
		input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	task automatic wr(input logic [23:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// read; data stand in the cycle after the read edge
	task automatic rd(input logic [23:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		chk("rdata", {8'h00, e}, {8'h00, reg_rdata});
	endtask : rd

	// period of a tick, measured after two ticks so old counts are gone
	task automatic per(input int s);
		int k;
		p = 16'h0000;
		for (k = 0; k < 1200; k++) begin
			@(posedge sys_clk);
			#1;
			if (tk(s) === 1'b1 && p == 16'h0001) break;
			if (tk(s) === 1'b1) p = 16'h0001;
		end
		p = 16'h0000;
		for (k = 0; k < 600; k++) begin
			@(posedge sys_clk);
			#1;
			p = p + 16'h0001;
			if (tk(s) === 1'b1) break;
		end
	endtask : per

	task automatic test_done;
		$display("errors %0d checks %0d", err_total, samples_checked);
		if (err_total == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : test_done

	// cut a hang short
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 30000) begin
			err_total++;
			test_done();
		end
	end

	// main sequence
	initial begin
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		#1;
		chk("chip_reset_n", 16'h0000, {15'h0000, chip_reset_n});
		chk("pll_mode", 16'h0004, {13'h0000, pll_mode});
		chk("pll_mult", 16'h0004, {13'h0000, pll_mult});
		rd(`CRC_ADDR_CTRL, 8'h26);
		rd(`CRC_ADDR_FAST, 8'h4f);
		rd(`CRC_ADDR_SLOW, 8'hb6);
		rd(`CRC_ADDR_AUX, 8'hff);
		rd(24'hff_fc48, 8'h00);
		// stabilisation count while the pin is still held low
		osc_stable <= 1'b1;
		n = 0;
		while (main_clock_good !== 1'b1 && n < 200) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		chk("good delay", {2'b00, STAB} + 16'h0002, 16'(n));
		chk("chip_reset_n", 16'h0000, {15'h0000, chip_reset_n});
		io_ok <= 1'b1;
		core_ok <= 1'b1;
		repeat (14) @(posedge sys_clk);
		#1;
		chk("chip_reset_n", 16'h0001, {15'h0000, chip_reset_n});
		// control register refusals and accepted writes
		for (int i = 0; i < 6; i++) begin
			pll_locked <= (i > 1);
			wr(`CRC_ADDR_CTRL, cw[i]);
			rd(`CRC_ADDR_CTRL, ce[i]);
		end
		chk("pll_stop", 16'h0001, {15'h0000, pll_stop});
		chk("fast_src_sel", 16'h0001, {15'h0000, fast_src_sel});
		wr(`CRC_ADDR_SLOW, 8'h02);
		per(3);
		chk("slow period", 16'h0006, p);
		// oscillator select refused while the oscillator is not toggling
		slow_osc_good <= 1'b0;
		wr(`CRC_ADDR_CTRL, 8'h1f);
		rd(`CRC_ADDR_CTRL, 8'h1e);
		slow_osc_good <= 1'b1;
		wr(`CRC_ADDR_CTRL, 8'h1f);
		rd(`CRC_ADDR_CTRL, 8'h1f);
		chk("slow_src_sel", 16'h0001, {15'h0000, slow_src_sel});
		// fast prescaler written only while running from the main clock
		for (int i = 0; i < 7; i++) begin
			seed = xs(seed);
			v = (i == 0) ? 8'h80 : (i == 1) ? 8'h3f :
				(i == 2) ? 8'h41 : seed[7:0];
			wr(`CRC_ADDR_FAST, v);
			rd(`CRC_ADDR_FAST, v & 8'h7f);
			chk("pll_mode", 16'(v[6:4]), 16'(pll_mode));
			chk("pll_mult", 16'(mult_of(v[6:4])), 16'(pll_mult));
			per(0);
			chk("sys period", {12'h000, v[3:0]} + 16'h0001, p);
		end
		vf = v;
		// auxiliary dividers
		seed = xs(seed);
		v = seed[7:0];
		wr(`CRC_ADDR_AUX, v);
		rd(`CRC_ADDR_AUX, v);
		per(1);
		chk("aux1 period", {12'h000, v[7:4]} + 16'h0001, p);
		per(2);
		chk("aux2 period", {12'h000, v[3:0]} + 16'h0001, p);
		// power-down: pin low, then main clock stops
		io_ok <= 1'b0;
		repeat (3) @(posedge sys_clk);
		#1;
		chk("chip_reset_n", 16'h0000, {15'h0000, chip_reset_n});
		osc_stable <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
		chk("main_clock_good", 16'h0000, {15'h0000, main_clock_good});
		n = 0;
		repeat (40) begin
			@(posedge sys_clk);
			#1;
			n += int'(aux1_tick | aux2_tick);
		end
		chk("aux ticks stopped", 16'h0000, 16'(n));
		io_ok <= 1'b1;
		@(posedge sys_clk);
		osc_stable <= 1'b1;
		repeat (60) @(posedge sys_clk);
		#1;
		chk("chip_reset_n", 16'h0001, {15'h0000, chip_reset_n});
		// mid-run reset in programming mode keeps the fast prescaler
		prog_mode <= 1'b1;
		rst_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		prog_mode <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk("chip_reset_n", 16'h0000, {15'h0000, chip_reset_n});
		rd(`CRC_ADDR_FAST, vf & 8'h7f);
		rd(`CRC_ADDR_CTRL, 8'h26);
		repeat (30) @(posedge sys_clk);
		#1;
		chk("chip_reset_n", 16'h0001, {15'h0000, chip_reset_n});
		test_done();
	end
endmodule : clock_reset_control_tb_top
